// *** core/sirs_pkg.sv ***
// constants for the safety init and release sequencer
package sirs_pkg;

    // ****************************************
    // link register addresses
    // ****************************************
    localparam logic [3:0] ADDR_WD_WINDOW     = 4'h0;
    localparam logic [3:0] ADDR_WD_WINDOW_INV = 4'h1;
    localparam logic [3:0] ADDR_SAFE_IN       = 4'h2;
    localparam logic [3:0] ADDR_SAFE_IN_INV   = 4'h3;
    localparam logic [3:0] ADDR_WD_ANSWER     = 4'h4;
    localparam logic [3:0] ADDR_SAFETY_STATE  = 4'h5;
    localparam logic [3:0] ADDR_RELEASE       = 4'h6;
    localparam logic [3:0] ADDR_MAIN_FLAG     = 4'h7;
    localparam logic [3:0] ADDR_VMON_STATUS   = 4'h8;
    localparam logic [3:0] ADDR_MIRROR_CFG    = 4'h9;

    // ****************************************
    // codes and field positions
    // ****************************************
    localparam logic [15:0] CODE_GOOD_ANSWER  = 16'h5AB2;
    localparam logic [15:0] CODE_RELEASE      = 16'hB2A5;
    localparam logic [15:0] CODE_MAIN_CLEAR   = 16'h40F1;
    localparam logic [15:0] CODE_VMON_CLEAR   = 16'h4550;
    localparam int          DEBUG_LEAVE_BIT   = 14;
    localparam int          WIN_PERIOD_LSB    = 0;
    localparam logic [3:0]  WIN_PERIOD_OFF    = 4'h0;
    localparam int          PAIR_CFG_LSB      = 8;
    localparam logic [1:0]  PAIR_CFG_BY_PAIR  = 2'h1;
    localparam int          PAIR_POL_BIT      = 12;
    localparam int          CFG_WD_DIS_BIT    = 15;
    localparam int          CFG_WD_SEL_BIT    = 14;

    // ****************************************
    // reset values and counts
    // ****************************************
    localparam logic [15:0] WD_WINDOW_RST     = 16'h0003;
    localparam logic [15:0] SAFE_IN_RST       = 16'h0000;
    localparam logic [2:0]  FLT_CNT_RST       = 3'h6;
    localparam logic [2:0]  FLT_CNT_MAX       = 3'h7;
    localparam logic [2:0]  GOOD_STREAK_CLEAR = 3'h7;
    localparam logic [1:0]  FUSE_BURN_MAX     = 2'h3;
    localparam logic [6:0]  I2C_DBG_MAIN      = 7'h20;
    localparam logic [6:0]  I2C_DBG_FS        = 7'h21;
    localparam logic        STORE_MIRROR      = 1'b0;
    localparam logic        STORE_FUSE        = 1'b1;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_READ,
        ST_RUN,
        ST_FAIL
    } sirs_state_e;

endpackage

// *** core/sirs_cfg_store.sv ***
// two-word configuration store: mirror word and burned fuse word
module sirs_cfg_store (
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst,
    // write side
    input  wire logic        mirror_we,
    input  wire logic [15:0] mirror_wdata,
    input  wire logic        burn_req,
    // read side
    output logic [15:0]      mirror_q,
    output logic             mirror_valid_q,
    output logic [15:0]      fuse_q,
    output logic             fuse_valid_q,
    output logic [1:0]       burn_count_q
);

    logic [15:0] mem [0:1];
    logic        burn_ok;

    assign burn_ok = burn_req && mirror_valid_q && (burn_count_q < sirs_pkg::FUSE_BURN_MAX);

    // ****************************************
    // storage; fuses survive reset, valid bits do not model that
    // ****************************************
    always_ff @(posedge sys_clk) begin
        if (mirror_we) begin
            mem[sirs_pkg::STORE_MIRROR] <= mirror_wdata;
        end
        if (burn_ok) begin
            mem[sirs_pkg::STORE_FUSE] <= mem[sirs_pkg::STORE_MIRROR];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            mirror_valid_q <= 1'b0;
        end else if (mirror_we) begin
            mirror_valid_q <= 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            fuse_valid_q <= 1'b0;
            burn_count_q <= 2'h0;
        end else if (burn_ok) begin
            fuse_valid_q <= 1'b1;
            burn_count_q <= burn_count_q + 2'h1;
        end
    end

    // registered read of both words
    always_ff @(posedge sys_clk) begin
        mirror_q <= mem[sirs_pkg::STORE_MIRROR];
        fuse_q   <= mem[sirs_pkg::STORE_FUSE];
    end

endmodule

// *** core/sirs_core.sv ***
// safety init and release sequencer with link-clocked register writes
module sirs_core (
    // system clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst,
    // link write port
    input  wire logic        link_clk,
    input  wire logic        link_wr_valid,
    input  wire logic [3:0]  link_wr_addr,
    input  wire logic [15:0] link_wr_data,
    output logic             link_wr_ready,
    // pins
    input  wire logic        debug_pin,
    input  wire logic        fault_input_one,
    input  wire logic        fault_input_two,
    input  wire logic [3:0]  main_flag_events,
    input  wire logic [3:0]  vmon_uv_events,
    // fuse programming
    input  wire logic        fuse_burn,
    // status and outputs
    output logic             safe_state_output,
    output logic             regulators_on,
    output logic             wdog_running,
    output logic             init_closed,
    output logic             debug_mode,
    output logic             start_failed,
    output logic [2:0]       fault_error_counter,
    output logic [3:0]       main_flags,
    output logic [3:0]       vmon_uv_flags,
    output logic [6:0]       i2c_addr_main,
    output logic [6:0]       i2c_addr_fs,
    output logic [1:0]       fuse_burn_count
);

    function automatic logic inv_ok(input logic [15:0] a, input logic [15:0] b);
        return b == ~a;
    endfunction

    // ****************************************
    // link domain: capture and toggle request
    // ****************************************
    logic        lrst_s1_q, lrst_s2_q;
    logic        lreq_tgl_q;
    logic        lack_s1_q, lack_s2_q;
    logic [3:0]  lhold_addr_q;
    logic [15:0] lhold_data_q;
    logic        lready_q;
    logic        laccept;
    logic        ack_tgl_q;

    assign laccept = link_wr_valid && lready_q;

    always_ff @(posedge link_clk) begin
        lrst_s1_q <= rst;
        lrst_s2_q <= lrst_s1_q;
    end

    always_ff @(posedge link_clk) begin
        lack_s1_q <= ack_tgl_q;
        lack_s2_q <= lack_s1_q;
    end

    always_ff @(posedge link_clk) begin
        if (lrst_s2_q) begin
            lreq_tgl_q   <= 1'b0;
            lready_q     <= 1'b0;
            lhold_addr_q <= 4'h0;
            lhold_data_q <= 16'h0000;
        end else if (laccept) begin
            lreq_tgl_q   <= ~lreq_tgl_q;
            lready_q     <= 1'b0;
            lhold_addr_q <= link_wr_addr;
            lhold_data_q <= link_wr_data;
        end else begin
            lready_q     <= (lreq_tgl_q == lack_s2_q);
        end
    end

    assign link_wr_ready = lready_q;

    // ****************************************
    // system domain: take the held word
    // ****************************************
    logic        sreq_s1_q, sreq_s2_q, sreq_s3_q;
    logic        wr_evt;
    logic [3:0]  wr_addr;
    logic [15:0] wr_data;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            sreq_s1_q <= 1'b0;
            sreq_s2_q <= 1'b0;
            sreq_s3_q <= 1'b0;
            ack_tgl_q <= 1'b0;
        end else begin
            sreq_s1_q <= lreq_tgl_q;
            sreq_s2_q <= sreq_s1_q;
            sreq_s3_q <= sreq_s2_q;
            ack_tgl_q <= sreq_s2_q;
        end
    end

    // held word is stable while the link side waits for the ack
    assign wr_evt  = sreq_s2_q != sreq_s3_q;
    assign wr_addr = lhold_addr_q;
    assign wr_data = lhold_data_q;

    // ****************************************
    // pin synchronisers
    // ****************************************
    logic [10:0] pin_s1_q, pin_s2_q;
    logic        dbg_pin_s, flt1_s, flt2_s;
    logic [3:0]  mflag_s, vmon_s;

    always_ff @(posedge sys_clk) begin
        pin_s1_q <= {debug_pin, fault_input_one, fault_input_two,
                     main_flag_events, vmon_uv_events};
        pin_s2_q <= pin_s1_q;
    end

    assign {dbg_pin_s, flt1_s, flt2_s, mflag_s, vmon_s} = pin_s2_q;

    // ****************************************
    // configuration store and start-up
    // ****************************************
    logic [15:0] mirror_w, fuse_w;
    logic        mirror_v, fuse_v;
    logic        mirror_we;
    sirs_pkg::sirs_state_e state_q;
    logic [15:0] cfg_q;
    logic        cfg_from_mirror_q;

    assign mirror_we = wr_evt && (wr_addr == sirs_pkg::ADDR_MIRROR_CFG) && dbg_pin_s;

    sirs_cfg_store u_store (
        .sys_clk        (sys_clk),
        .rst            (rst),
        .mirror_we      (mirror_we),
        .mirror_wdata   (wr_data),
        .burn_req       (fuse_burn),
        .mirror_q       (mirror_w),
        .mirror_valid_q (mirror_v),
        .fuse_q         (fuse_w),
        .fuse_valid_q   (fuse_v),
        .burn_count_q   (fuse_burn_count)
    );

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_q           <= sirs_pkg::ST_IDLE;
            cfg_q             <= 16'h0000;
            cfg_from_mirror_q <= 1'b0;
        end else begin
            unique case (state_q)
                sirs_pkg::ST_IDLE: begin
                    state_q <= sirs_pkg::ST_READ;
                end
                sirs_pkg::ST_READ: begin
                    if (mirror_v) begin
                        cfg_q             <= mirror_w;
                        cfg_from_mirror_q <= 1'b1;
                        state_q           <= sirs_pkg::ST_RUN;
                    end else if (fuse_v) begin
                        cfg_q   <= fuse_w;
                        state_q <= sirs_pkg::ST_RUN;
                    end else begin
                        state_q <= sirs_pkg::ST_FAIL;
                    end
                end
                sirs_pkg::ST_RUN: begin
                    state_q <= sirs_pkg::ST_RUN;
                end
                sirs_pkg::ST_FAIL: begin
                    // retry once the mirror word or the fuse word is valid
                    if (mirror_v || fuse_v) begin
                        state_q <= sirs_pkg::ST_READ;
                    end
                end
            endcase
        end
    end

    logic running, wd_cfg_en, wd_simple;
    assign running   = state_q == sirs_pkg::ST_RUN;
    assign wd_cfg_en = !cfg_q[sirs_pkg::CFG_WD_DIS_BIT];
    assign wd_simple = !cfg_q[sirs_pkg::CFG_WD_SEL_BIT];

    // ****************************************
    // safety configuration with inverse check
    // ****************************************
    logic [15:0] win_q, win_pend_q, safe_in_q, safe_pend_q;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            win_q       <= sirs_pkg::WD_WINDOW_RST;
            win_pend_q  <= sirs_pkg::WD_WINDOW_RST;
            safe_in_q   <= sirs_pkg::SAFE_IN_RST;
            safe_pend_q <= sirs_pkg::SAFE_IN_RST;
        end else if (wr_evt && !init_closed) begin
            unique case (wr_addr)
                sirs_pkg::ADDR_WD_WINDOW:   win_pend_q  <= wr_data;
                sirs_pkg::ADDR_SAFE_IN:     safe_pend_q <= wr_data;
                sirs_pkg::ADDR_WD_WINDOW_INV: begin
                    if (inv_ok(win_pend_q, wr_data)) begin
                        win_q <= win_pend_q;
                    end
                end
                sirs_pkg::ADDR_SAFE_IN_INV: begin
                    if (inv_ok(safe_pend_q, wr_data)) begin
                        safe_in_q <= safe_pend_q;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // ****************************************
    // fault pair monitoring
    // ****************************************
    logic fault_now, fault_prev_q, fault_rise;
    logic pair_pol;

    assign pair_pol  = safe_in_q[sirs_pkg::PAIR_POL_BIT];
    assign fault_now = (safe_in_q[sirs_pkg::PAIR_CFG_LSB +: 2] == sirs_pkg::PAIR_CFG_BY_PAIR)
                       && (pair_pol ? (!flt1_s || !flt2_s) : (flt1_s || flt2_s));

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            fault_prev_q <= 1'b0;
        end else begin
            fault_prev_q <= fault_now;
        end
    end

    assign fault_rise = fault_now && !fault_prev_q;

    // ****************************************
    // watchdog answers, init phase, error counter
    // ****************************************
    logic ans_wr, good_ans;
    logic [2:0] streak_q;

    assign ans_wr   = wr_evt && (wr_addr == sirs_pkg::ADDR_WD_ANSWER) && running;
    assign good_ans = ans_wr && wd_simple && (wr_data == sirs_pkg::CODE_GOOD_ANSWER);

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            init_closed <= 1'b0;
        end else if (good_ans) begin
            init_closed <= 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            streak_q            <= 3'h0;
            fault_error_counter <= sirs_pkg::FLT_CNT_RST;
        end else if (fault_rise || (ans_wr && !good_ans)) begin
            streak_q <= 3'h0;
            if (fault_error_counter != sirs_pkg::FLT_CNT_MAX) begin
                fault_error_counter <= fault_error_counter + 3'h1;
            end
        end else if (good_ans) begin
            if (streak_q + 3'h1 == sirs_pkg::GOOD_STREAK_CLEAR) begin
                streak_q            <= 3'h0;
                fault_error_counter <= 3'h0;
            end else begin
                streak_q <= streak_q + 3'h1;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            wdog_running <= 1'b0;
        end else begin
            wdog_running <= running && init_closed && wd_cfg_en
                && (win_q[sirs_pkg::WIN_PERIOD_LSB +: 4] != sirs_pkg::WIN_PERIOD_OFF);
        end
    end

    // ****************************************
    // debug mode and regulators
    // ****************************************
    logic dbg_leave;
    assign dbg_leave = wr_evt && (wr_addr == sirs_pkg::ADDR_SAFETY_STATE)
                       && wr_data[sirs_pkg::DEBUG_LEAVE_BIT];

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            debug_mode <= 1'b1;
        end else if (dbg_leave) begin
            debug_mode <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            regulators_on <= 1'b0;
            start_failed  <= 1'b0;
        end else begin
            regulators_on <= running && init_closed && !debug_mode;
            start_failed  <= state_q == sirs_pkg::ST_FAIL;
        end
    end

    // ****************************************
    // safe-state output release
    // ****************************************
    logic rel_ok;
    // a fault-pair fault drops the output again; a new release code is needed
    assign rel_ok = !debug_mode && (fault_error_counter == 3'h0)
                    && wd_cfg_en && init_closed && running && !fault_now;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            safe_state_output <= 1'b0;
        end else if (fault_now || fault_rise) begin
            safe_state_output <= 1'b0;
        end else if (wr_evt && (wr_addr == sirs_pkg::ADDR_RELEASE)
                     && (wr_data == sirs_pkg::CODE_RELEASE) && rel_ok) begin
            safe_state_output <= 1'b1;
        end
    end

    // ****************************************
    // sticky flags, set wins over clear
    // ****************************************
    logic clr_main, clr_vmon;
    assign clr_main = wr_evt && (wr_addr == sirs_pkg::ADDR_MAIN_FLAG)
                      && (wr_data == sirs_pkg::CODE_MAIN_CLEAR);
    assign clr_vmon = wr_evt && (wr_addr == sirs_pkg::ADDR_VMON_STATUS)
                      && (wr_data == sirs_pkg::CODE_VMON_CLEAR);

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            main_flags <= 4'h0;
        end else begin
            main_flags <= (clr_main ? 4'h0 : main_flags) | mflag_s;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            vmon_uv_flags <= 4'h0;
        end else begin
            vmon_uv_flags <= (clr_vmon ? 4'h0 : vmon_uv_flags) | vmon_s;
        end
    end

    // ****************************************
    // I2C address selection
    // ****************************************
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            i2c_addr_main <= sirs_pkg::I2C_DBG_MAIN;
            i2c_addr_fs   <= sirs_pkg::I2C_DBG_FS;
        end else if (dbg_pin_s) begin
            i2c_addr_main <= sirs_pkg::I2C_DBG_MAIN;
            i2c_addr_fs   <= sirs_pkg::I2C_DBG_FS;
        end else if (mirror_v && cfg_from_mirror_q) begin
            i2c_addr_main <= mirror_w[6:0];
            i2c_addr_fs   <= mirror_w[6:0] + 7'h01;
        end else if (fuse_v) begin
            i2c_addr_main <= fuse_w[6:0];
            i2c_addr_fs   <= fuse_w[6:0] + 7'h01;
        end
    end

endmodule

// *** test/sirs_asserts.sv ***
// assertion checker on the sequencer core ports
module sirs_asserts (
    // clocks and reset
    input wire logic       sys_clk,
    input wire logic       rst,
    input wire logic       link_clk,
    // watched ports
    input wire logic       link_wr_valid,
    input wire logic       link_wr_ready,
    input wire logic       debug_pin,
    input wire logic       safe_state_output,
    input wire logic       regulators_on,
    input wire logic       wdog_running,
    input wire logic       init_closed,
    input wire logic       debug_mode,
    input wire logic       start_failed,
    input wire logic [2:0] fault_error_counter,
    input wire logic [6:0] i2c_addr_main,
    input wire logic [6:0] i2c_addr_fs,
    input wire logic [1:0] fuse_burn_count
);
    timeunit 1ns;
    timeprecision 1ns;
    // ****************************************
    // properties
    // ****************************************
    // regulators_on lags one cycle, so only a held debug mode counts
    property p_dbg_off;
        @(posedge sys_clk) disable iff (rst)
        debug_mode && $past(debug_mode) |-> !regulators_on;
    endproperty
    a_dbg_off: assert property (p_dbg_off)
        else $error("regulators on in debug mode");
    property p_init_wd;
        @(posedge sys_clk) disable iff (rst)
        !init_closed |-> !wdog_running && !regulators_on;
    endproperty
    a_init_wd: assert property (p_init_wd)
        else $error("watchdog or regulators before init closed");
    property p_rel_dbg;
        @(posedge sys_clk) disable iff (rst)
        $rose(safe_state_output) |-> !debug_mode;
    endproperty
    a_rel_dbg: assert property (p_rel_dbg)
        else $error("release while in debug mode");
    property p_rel_cnt;
        @(posedge sys_clk) disable iff (rst)
        $rose(safe_state_output) |-> fault_error_counter == 3'h0;
    endproperty
    a_rel_cnt: assert property (p_rel_cnt)
        else $error("release with nonzero fault counter");
    property p_rel_init;
        @(posedge sys_clk) disable iff (rst)
        safe_state_output |-> init_closed;
    endproperty
    a_rel_init: assert property (p_rel_init)
        else $error("safe output released before init closed");
    property p_nocfg;
        @(posedge sys_clk) disable iff (rst)
        start_failed |-> !init_closed && !regulators_on;
    endproperty
    a_nocfg: assert property (p_nocfg)
        else $error("start-up proceeded without configuration");
    property p_i2c_dbg;
        @(posedge sys_clk) disable iff (rst)
        debug_pin [*4] |=> i2c_addr_main == 7'h20 && i2c_addr_fs == 7'h21;
    endproperty
    a_i2c_dbg: assert property (p_i2c_dbg)
        else $error("debug pin addresses wrong");
    property p_i2c_fs;
        @(posedge sys_clk) disable iff (rst)
        !debug_pin [*6] |=> i2c_addr_fs == i2c_addr_main + 7'h1;
    endproperty
    a_i2c_fs: assert property (p_i2c_fs)
        else $error("fail-safe address not main plus one");
    property p_burn_cap;
        @(posedge sys_clk) disable iff (rst)
        fuse_burn_count == 2'h3 |=> fuse_burn_count == 2'h3;
    endproperty
    a_burn_cap: assert property (p_burn_cap)
        else $error("fuse burn count moved past three");
    property p_link_take;
        @(posedge link_clk) disable iff (rst)
        link_wr_valid && link_wr_ready |=> !link_wr_ready;
    endproperty
    a_link_take: assert property (p_link_take)
        else $error("link ready held after a taken write");
    c_rel: cover property (@(posedge sys_clk) $rose(safe_state_output));
    c_fail: cover property (@(posedge sys_clk) start_failed);
    c_burn: cover property (@(posedge sys_clk) fuse_burn_count == 2'h3);
endmodule

bind sirs_core sirs_asserts sirs_asserts_inst (.sys_clk, .rst, .link_clk, .link_wr_valid,
    .link_wr_ready, .debug_pin, .safe_state_output, .regulators_on, .wdog_running,
    .init_closed, .debug_mode, .start_failed, .fault_error_counter, .i2c_addr_main,
    .i2c_addr_fs, .fuse_burn_count);

// *** test/sirs_host.sv ***
// host model issuing register writes on the link
module sirs_host (
    // link
    input  wire logic        link_clk,
    input  wire logic        link_wr_ready,
    output logic             link_wr_valid,
    output logic [3:0]       link_wr_addr,
    output logic [15:0]      link_wr_data
);
    timeunit 1ns;
    timeprecision 1ns;
    int n;
    initial begin
        link_wr_valid = 1'b0;
        link_wr_addr  = 4'hF;
        link_wr_data  = 16'h0000;
    end
    // one write in flight; returns once the ack has come back
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        n = 0;
        do begin
            @(posedge link_clk);
            n++;
        end while (link_wr_ready !== 1'b1 && n < 200);
        link_wr_valid <= 1'b1;
        link_wr_addr  <= a;
        link_wr_data  <= d;
        do @(posedge link_clk); while (link_wr_ready !== 1'b1 && n++ < 400);
        // released lines show junk, never the last value
        link_wr_valid <= 1'b0;
        link_wr_addr  <= ~a;
        link_wr_data  <= ~d;
        do @(posedge link_clk); while (link_wr_ready !== 1'b1 && n++ < 600);
    endtask
endmodule

// *** test/tb.sv ***
// self-checking testbench for the sequencer core
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin miscompares++; \
    $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic        sys_clk, rst, link_clk, link_wr_valid, link_wr_ready, debug_pin;
    logic        fault_input_one, fault_input_two, fuse_burn, safe_state_output;
    logic        regulators_on, wdog_running, init_closed, debug_mode, start_failed;
    logic [3:0]  link_wr_addr, main_flag_events, vmon_uv_events, main_flags, vmon_uv_flags;
    logic [15:0] link_wr_data;
    logic [2:0]  fault_error_counter;
    logic [6:0]  i2c_addr_main, i2c_addr_fs;
    logic [1:0]  fuse_burn_count;
    int          miscompares = 0;
    int          n_checks = 0;
    sirs_core sirs_core_inst (.sys_clk, .rst, .link_clk, .link_wr_valid, .link_wr_addr,
        .link_wr_data, .link_wr_ready, .debug_pin, .fault_input_one, .fault_input_two,
        .main_flag_events, .vmon_uv_events, .fuse_burn, .safe_state_output, .regulators_on,
        .wdog_running, .init_closed, .debug_mode, .start_failed, .fault_error_counter,
        .main_flags, .vmon_uv_flags, .i2c_addr_main, .i2c_addr_fs, .fuse_burn_count);
    sirs_host sirs_host_inst (.link_clk, .link_wr_ready, .link_wr_valid, .link_wr_addr,
        .link_wr_data);
    // ****************************************
    // clocks and helpers
    // ****************************************
    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    // odd offset keeps the link phase unrelated to the system clock
    initial begin
        link_clk = 1'b0;
        #13;
        forever #40 link_clk = ~link_clk;
    end
    task automatic cyc(input int k);
        repeat (k) @(posedge sys_clk);
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        sirs_host_inst.wr(a, d);
        cyc(2);
        // a host wait that ran out leaves ready low here
        `CHK(link_wr_ready, 1'b1)
    endtask
    task automatic conclude();
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_boot();
        `CHK(start_failed, 1'b1)
        wr(sirs_pkg::ADDR_MIRROR_CFG, 16'h0012);
        cyc(10);
        `CHK(start_failed, 1'b0)
        `CHK(i2c_addr_main, 7'h20)
        `CHK(i2c_addr_fs, 7'h21)
        $display("boot done");
    endtask
    task automatic t_init();
        wr(sirs_pkg::ADDR_WD_WINDOW, 16'h0200);
        wr(sirs_pkg::ADDR_WD_WINDOW_INV, 16'hFDFF);
        wr(sirs_pkg::ADDR_SAFE_IN, 16'h51C6);
        wr(sirs_pkg::ADDR_SAFE_IN_INV, 16'hAE39);
        `CHK(init_closed, 1'b0)
        wr(sirs_pkg::ADDR_WD_ANSWER, 16'h5AB2);
        `CHK(init_closed, 1'b1)
        `CHK(wdog_running, 1'b0)
        `CHK(regulators_on, 1'b0)
        $display("init done");
    endtask
    task automatic t_debug();
        wr(sirs_pkg::ADDR_RELEASE, 16'hB2A5);
        `CHK(safe_state_output, 1'b0)
        wr(sirs_pkg::ADDR_SAFETY_STATE, 16'h4000);
        `CHK(debug_mode, 1'b0)
        `CHK(regulators_on, 1'b1)
        $display("debug done");
    endtask
    task automatic t_streak();
        repeat (5) wr(sirs_pkg::ADDR_WD_ANSWER, 16'h5AB2);
        `CHK(fault_error_counter, 3'h6)
        wr(sirs_pkg::ADDR_WD_ANSWER, 16'h5AB2);
        `CHK(fault_error_counter, 3'h0)
        wr(sirs_pkg::ADDR_RELEASE, 16'hB2A5);
        `CHK(safe_state_output, 1'b1)
        fault_input_one <= 1'b0;
        cyc(8);
        `CHK(safe_state_output, 1'b0)
        `CHK(fault_error_counter, 3'h1)
        $display("streak done");
    endtask
    task automatic t_misc();
        debug_pin <= 1'b0;
        main_flag_events <= 4'hF;
        vmon_uv_events <= 4'hF;
        cyc(6);
        main_flag_events <= 4'h0;
        vmon_uv_events <= 4'h0;
        cyc(6);
        `CHK(i2c_addr_main, 7'h12)
        `CHK(i2c_addr_fs, 7'h13)
        `CHK({main_flags, vmon_uv_flags}, 8'hFF)
        wr(sirs_pkg::ADDR_MAIN_FLAG, 16'h40F1);
        `CHK(main_flags, 4'h0)
        wr(sirs_pkg::ADDR_VMON_STATUS, 16'h4550);
        `CHK(vmon_uv_flags, 4'h0)
        repeat (4) begin
            fuse_burn <= 1'b1;
            cyc(1);
            fuse_burn <= 1'b0;
            cyc(2);
        end
        `CHK(fuse_burn_count, 2'h3)
        $display("misc done");
    endtask
    // ****************************************
    // main sequence and watchdog
    // ****************************************
    initial begin
        rst = 1'b1;
        debug_pin = 1'b1;
        fault_input_one = 1'b1;
        fault_input_two = 1'b1;
        main_flag_events = 4'h0;
        vmon_uv_events = 4'h0;
        fuse_burn = 1'b0;
        cyc(16);
        rst <= 1'b0;
        cyc(10);
        t_boot();
        t_init();
        t_debug();
        t_streak();
        t_misc();
        conclude();
    end
    initial begin
        #400000;
        miscompares++;
        conclude();
    end
endmodule
